// >>> verilog/adc_seq_pkg.sv
// Constants, types and helper functions of the sample and convert sequencer
//
// Contract
// - Short sampling window lasts twelve serial clocks.
// - Sampling starts after fourth serial falling edge.
// - Long sampling window lasts forty-four serial clocks.
// - Strobe low samples, rising edge starts conversion.
// - Strobe enters extended mode; two triggers exit.
// - Conversion starts after sixteenth or forty-eighth fall.
// - Conversion lasts eighteen or thirteen clocks, plus delay.
// - Conversion clock: oscillator or four serial clocks.
// - Done low during conversion; interrupt low at end.
// - One-shot converts once, bypassing the FIFO.
// - Repeat fills FIFO to threshold, then interrupts.
// - Next repeat operation overwrites unread FIFO.
// - Select commands during operations are dummies.
// - Strobe repeat may restart right after threshold.
// - Sweep converts sequence channels until threshold.
// - Full sweep idles until read or configuration.
// - Repeat sweep restarts at once, overwriting FIFO.
// - Threshold code selects level seven, five, three, one.
// - Shared pin shows interrupt or conversion done.
// - Configuration write never converts nor signals.
package adc_seq_pkg;

	// Clock and internal timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int INT_DELAY_NS = 15;
	localparam int INT_DELAY_CYC = (INT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] INT_DELAY_CNT = 2'(INT_DELAY_CYC - 1);
	localparam int OSC_PERIOD_NS = 100;
	localparam int OSC_CYC = OSC_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [3:0] OSC_CNT = 4'(OSC_CYC - 1);

	// Serial clock positions and window lengths
	localparam logic [5:0] SAMPLE_START_FALL = 6'h04;
	localparam logic [5:0] SHORT_WINDOW = 6'h0C;
	localparam logic [5:0] LONG_WINDOW = 6'h2C;
	localparam logic [1:0] SCLK_PER_CONV_LAST = 2'h3;
	localparam logic [4:0] CONV_CLKS_14 = 5'h12;
	localparam logic [4:0] CONV_CLKS_12 = 5'h0D;
	localparam logic EXT_EXIT_LAST = 1'h1;

	// FIFO levels that end an operation
	localparam logic [3:0] LEVEL_FULL = 4'h7;
	localparam logic [3:0] LEVEL_3Q = 4'h5;
	localparam logic [3:0] LEVEL_HALF = 4'h3;
	localparam logic [3:0] LEVEL_1Q = 4'h1;
	localparam int FIFO_DEPTH = 8;
	localparam int VALUE_BITS = 14;
	localparam int CH_BITS = 3;

	typedef enum logic [1:0] {
		MODE_ONE_SHOT = 2'b00,
		MODE_REPEAT = 2'b01,
		MODE_SWEEP = 2'b10,
		MODE_REPEAT_SWEEP = 2'b11
	} mode_e;

	typedef enum logic [1:0] {
		CMD_SELECT = 2'b00,
		CMD_FIFO_READ = 2'b01,
		CMD_CONFIG_WRITE = 2'b10,
		CMD_OTHER = 2'b11
	} cmd_e;

	typedef struct packed {
		mode_e mode;
		logic [1:0] sweep_seq;
		logic eoc_select;
		logic [1:0] threshold;
		logic long_sample;
		logic ext_clock;
		logic res14;
	} config_word_s;

	typedef struct packed {
		logic [CH_BITS-1:0] channel;
		logic [VALUE_BITS-1:0] value;
	} result_s;

	// Number of samples that completes an operation
	function automatic logic [3:0] fill_target(input logic [1:0] th);
		unique case (th)
			2'b00: fill_target = LEVEL_FULL + 4'h1;
			2'b01: fill_target = LEVEL_3Q + 4'h1;
			2'b10: fill_target = LEVEL_HALF + 4'h1;
			2'b11: fill_target = LEVEL_1Q + 4'h1;
		endcase
	endfunction

	// Channel visited at a given sweep position
	function automatic logic [2:0] sweep_channel(input logic [1:0] seq, input logic [2:0] idx);
		unique case (seq)
			2'b00: sweep_channel = idx;
			2'b01: sweep_channel = {idx[1:0], 1'b0};
			2'b10: sweep_channel = {idx[2:1], 1'b0};
			2'b11: sweep_channel = {1'b0, idx[0], 1'b0};
		endcase
	endfunction

endpackage

// >>> verilog/pin_sync.sv
// Two-stage pin synchroniser with edge detection
`timescale 1ns/100ps
module pin_sync #(
	parameter logic INIT = 1'b1
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_pin,
	output logic o_level,
	output logic o_rise,
	output logic o_fall
);
	logic meta;
	logic stable;
	logic prev;

	// Only the second stage looks at the first
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta <= INIT;
			stable <= INIT;
			prev <= INIT;
		end else begin
			meta <= i_pin;
			stable <= meta;
			prev <= stable;
		end
	end

	// Edges come from the settled stages only
	assign o_level = stable;
	assign o_rise = stable & ~prev;
	assign o_fall = ~stable & prev;
endmodule

// >>> verilog/result_fifo.sv
// Result FIFO with registered read data and flush
`timescale 1ns/100ps
module result_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_flush,
	input wire logic i_wr_valid,
	output logic o_wr_ready,
	input wire logic [WIDTH-1:0] i_wr_data,
	output logic o_rd_valid,
	input wire logic i_rd_ready,
	output logic [WIDTH-1:0] o_rd_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_idx;
	logic [AW-1:0] rd_idx;
	logic [AW:0] count;
	logic push;
	logic pop;
	logic [AW-1:0] next_rd_idx;
	logic [AW:0] next_count;

	assign push = i_wr_valid & o_wr_ready;
	assign pop = o_rd_valid & i_rd_ready;
	assign next_rd_idx = pop ? ((rd_idx == LAST_IDX) ? '0 : rd_idx + 1'b1) : rd_idx;

	// Occupancy after this edge
	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	// Storage; flush only discards, old words are overwritten later
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_idx] <= i_wr_data;
		end
	end

	// Pointers and flags are registered so both sides see clean levels
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_idx <= '0;
			rd_idx <= '0;
			count <= '0;
			o_rd_valid <= 1'b0;
			o_wr_ready <= 1'b1;
		end else if (i_flush) begin
			wr_idx <= '0;
			rd_idx <= '0;
			count <= '0;
			o_rd_valid <= 1'b0;
			o_wr_ready <= 1'b1;
		end else begin
			if (push) begin
				wr_idx <= (wr_idx == LAST_IDX) ? '0 : wr_idx + 1'b1;
			end
			rd_idx <= next_rd_idx;
			count <= next_count;
			o_rd_valid <= (next_count != '0);
			o_wr_ready <= (next_count != DEPTH_CNT);
		end
	end

	// Read data register with bypass for a write into the head slot
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rd_data <= '0;
		end else if (push && wr_idx == next_rd_idx) begin
			o_rd_data <= i_wr_data;
		end else begin
			o_rd_data <= mem[next_rd_idx];
		end
	end
endmodule

// >>> verilog/adc_sample_convert_sequencer.sv
// Sampling and conversion sequencer with operation modes and result FIFO
`timescale 1ns/100ps
module adc_sample_convert_sequencer (
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic I_SCLK,
	input wire logic I_CS_N,
	input wire logic I_FRAME_SYNC_PULSE,
	input wire logic I_EXTERNAL_SAMPLE_STROBE_N,
	input wire adc_seq_pkg::cmd_e I_CMD,
	input wire logic [adc_seq_pkg::CH_BITS-1:0] I_CMD_CHANNEL,
	input wire adc_seq_pkg::config_word_s I_CONFIG_WORD,
	input wire logic [adc_seq_pkg::VALUE_BITS-1:0] I_CONV_VALUE,
	input wire logic I_RESULT_READY,
	output logic O_EOC_INT_N,
	output logic O_SAMPLING,
	output logic O_CONVERTING,
	output logic [adc_seq_pkg::CH_BITS-1:0] O_CHANNEL,
	output logic [adc_seq_pkg::VALUE_BITS-1:0] O_ONESHOT_RESULT,
	output adc_seq_pkg::result_s O_RESULT_DATA,
	output logic O_RESULT_VALID,
	output logic O_EXTENDED_MODE,
	output logic O_OP_ACTIVE,
	output logic O_HALTED
);
	import adc_seq_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_COMMAND = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_EXT_SAMPLE = 3'b011,
		ST_STROBE_DELAY = 3'b100,
		ST_CONVERT = 3'b101,
		ST_CONV_DELAY = 3'b110,
		ST_PUSH = 3'b111
	} state_e;

	state_e state;
	logic sclk_fall;
	logic cs_fall;
	logic fs_rise;
	logic strobe_level;
	logic strobe_fall;
	logic strobe_rise;
	logic [5:0] fall_cnt;
	logic [5:0] conv_start_fall;
	logic [4:0] conv_cnt;
	logic [4:0] conv_last;
	logic [1:0] sclk_div;
	logic [3:0] osc_cnt;
	logic [1:0] dly_cnt;
	logic [3:0] wr_count;
	logic [CH_BITS-1:0] sel_channel;
	logic [CH_BITS-1:0] next_channel;
	logic int_n;
	logic ext_exit_cnt;
	logic trig;
	logic fourth_fall;
	logic cmd_seen;
	logic normal_go;
	logic strobe_go;
	logic start_go;
	logic new_op;
	logic one_shot;
	logic conv_tick;
	logic osc_tick;
	logic conv_end;
	logic push_done;
	logic reach_target;
	logic fifo_ready;
	logic in_conv;
	result_s capture;

	pin_sync #(.INIT(1'b1)) u_sclk_sync (
		.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_pin(I_SCLK),
		.o_level(), .o_rise(), .o_fall(sclk_fall)
	);
	pin_sync #(.INIT(1'b1)) u_cs_sync (
		.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_pin(I_CS_N),
		.o_level(), .o_rise(), .o_fall(cs_fall)
	);
	pin_sync #(.INIT(1'b0)) u_fs_sync (
		.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_pin(I_FRAME_SYNC_PULSE),
		.o_level(), .o_rise(fs_rise), .o_fall()
	);
	pin_sync #(.INIT(1'b1)) u_strobe_sync (
		.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_pin(I_EXTERNAL_SAMPLE_STROBE_N),
		.o_level(strobe_level), .o_rise(strobe_rise), .o_fall(strobe_fall)
	);

	// Serial clock positions for the selected window length
	assign conv_start_fall = SAMPLE_START_FALL
		+ (I_CONFIG_WORD.long_sample ? LONG_WINDOW : SHORT_WINDOW);
	assign conv_last = (I_CONFIG_WORD.res14 ? CONV_CLKS_14 : CONV_CLKS_12) - 5'h01;
	assign one_shot = (I_CONFIG_WORD.mode == MODE_ONE_SHOT);

	// Cycle events; triggers are only taken between conversions
	assign trig = (state == ST_IDLE) && (cs_fall || fs_rise);
	assign fourth_fall = sclk_fall && (fall_cnt == SAMPLE_START_FALL - 6'h01);
	assign cmd_seen = (state == ST_COMMAND) && fourth_fall;
	// Read and configuration commands never sample
	assign normal_go = cmd_seen && (I_CMD == CMD_SELECT) && !O_EXTENDED_MODE
		&& !O_HALTED;
	assign strobe_go = ((state == ST_IDLE) || (state == ST_COMMAND)) && strobe_fall
		&& !O_HALTED;
	assign start_go = normal_go || strobe_go;
	assign new_op = start_go && !one_shot && !O_OP_ACTIVE;
	assign reach_target = (wr_count + 4'h1) == fill_target(I_CONFIG_WORD.threshold);
	assign conv_end = (state == ST_CONV_DELAY) && (dly_cnt == 2'h0);
	assign push_done = (state == ST_PUSH) && fifo_ready;
	assign in_conv = (state == ST_CONVERT) || (state == ST_CONV_DELAY);

	// Conversion clock from the oscillator or four serial clocks
	assign osc_tick = (osc_cnt == OSC_CNT);
	assign conv_tick = I_CONFIG_WORD.ext_clock
		? (sclk_fall && sclk_div == SCLK_PER_CONV_LAST) : osc_tick;

	// Channel for the sample being started; dummy selects keep the plan
	always_comb begin
		next_channel = O_CHANNEL;
		if (I_CONFIG_WORD.mode[1]) begin
			next_channel = sweep_channel(I_CONFIG_WORD.sweep_seq,
				new_op ? 3'h0 : wr_count[2:0]);
		end else if (one_shot || new_op) begin
			next_channel = normal_go ? I_CMD_CHANNEL : sel_channel;
		end
	end

	// Internal oscillator runs free so its ticks need no start-up
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			osc_cnt <= 4'h0;
		end else if (osc_tick) begin
			osc_cnt <= 4'h0;
		end else begin
			osc_cnt <= osc_cnt + 4'h1;
		end
	end

	// Main sequence of command, sampling and conversion periods
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state <= ST_IDLE;
			fall_cnt <= 6'h00;
			conv_cnt <= 5'h00;
			sclk_div <= 2'h0;
			dly_cnt <= 2'h0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (strobe_go) begin
						state <= ST_EXT_SAMPLE;
					end else if (trig) begin
						state <= ST_COMMAND;
						fall_cnt <= 6'h00;
					end
				end
				ST_COMMAND: begin
					if (strobe_go) begin
						state <= ST_EXT_SAMPLE;
					end else if (normal_go) begin
						state <= ST_SAMPLE;
						fall_cnt <= fall_cnt + 6'h01;
					end else if (cmd_seen) begin
						state <= ST_IDLE;
					end else if (sclk_fall) begin
						fall_cnt <= fall_cnt + 6'h01;
					end
				end
				ST_SAMPLE: begin
					if (sclk_fall) begin
						fall_cnt <= fall_cnt + 6'h01;
						if (fall_cnt == conv_start_fall - 6'h01) begin
							state <= ST_CONVERT;
							conv_cnt <= 5'h00;
							sclk_div <= 2'h0;
						end
					end
				end
				ST_EXT_SAMPLE: begin
					if (strobe_rise) begin
						state <= ST_STROBE_DELAY;
						dly_cnt <= INT_DELAY_CNT;
					end
				end
				ST_STROBE_DELAY: begin
					if (dly_cnt == 2'h0) begin
						state <= ST_CONVERT;
						conv_cnt <= 5'h00;
						sclk_div <= 2'h0;
					end else begin
						dly_cnt <= dly_cnt - 2'h1;
					end
				end
				ST_CONVERT: begin
					if (sclk_fall) begin
						sclk_div <= sclk_div + 2'h1;
					end
					if (conv_tick) begin
						conv_cnt <= conv_cnt + 5'h01;
						if (conv_cnt == conv_last) begin
							state <= ST_CONV_DELAY;
							dly_cnt <= INT_DELAY_CNT;
						end
					end
				end
				ST_CONV_DELAY: begin
					if (dly_cnt != 2'h0) begin
						dly_cnt <= dly_cnt - 2'h1;
					end else if (one_shot) begin
						state <= ST_IDLE;
					end else begin
						state <= ST_PUSH;
					end
				end
				ST_PUSH: begin
					// Waits here while the FIFO is full
					if (fifo_ready) begin
						state <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// Extended sampling mode entry and two-trigger exit
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_EXTENDED_MODE <= 1'b0;
			ext_exit_cnt <= 1'b0;
		end else if (strobe_fall) begin
			O_EXTENDED_MODE <= 1'b1;
			ext_exit_cnt <= 1'b0;
		end else if (trig && O_EXTENDED_MODE && strobe_level) begin
			if (ext_exit_cnt == EXT_EXIT_LAST) begin
				O_EXTENDED_MODE <= 1'b0;
				ext_exit_cnt <= 1'b0;
			end else begin
				ext_exit_cnt <= ext_exit_cnt + 1'b1;
			end
		end
	end

	// Operation bookkeeping: active flag, sweep halt and write count
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_OP_ACTIVE <= 1'b0;
			O_HALTED <= 1'b0;
			wr_count <= 4'h0;
		end else if (cmd_seen && I_CMD == CMD_CONFIG_WRITE) begin
			O_OP_ACTIVE <= 1'b0;
			O_HALTED <= 1'b0;
			wr_count <= 4'h0;
		end else if (push_done) begin
			if (reach_target) begin
				O_OP_ACTIVE <= 1'b0;
				O_HALTED <= (I_CONFIG_WORD.mode == MODE_SWEEP);
				wr_count <= 4'h0;
			end else begin
				wr_count <= wr_count + 4'h1;
			end
		end else if (new_op) begin
			O_OP_ACTIVE <= 1'b1;
			wr_count <= 4'h0;
		end else if (cmd_seen && I_CMD == CMD_FIFO_READ) begin
			O_HALTED <= 1'b0;
		end
	end

	// Channel latched by a real select, kept for strobe-started operations
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sel_channel <= '0;
			O_CHANNEL <= '0;
		end else begin
			if (cmd_seen && I_CMD == CMD_SELECT && (one_shot || !O_OP_ACTIVE)) begin
				sel_channel <= I_CMD_CHANNEL;
			end
			if (start_go) begin
				O_CHANNEL <= next_channel;
			end
		end
	end

	// Result capture at the end of the conversion period
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_ONESHOT_RESULT <= '0;
			capture <= '0;
		end else if (conv_end) begin
			if (one_shot) begin
				O_ONESHOT_RESULT <= I_CONV_VALUE;
			end else begin
				capture <= '{channel: O_CHANNEL, value: I_CONV_VALUE};
			end
		end
	end

	// Interrupt: low at one-shot conversion end or at threshold, released by the next cycle
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			int_n <= 1'b1;
		end else if ((conv_end && one_shot) || (push_done && reach_target)) begin
			int_n <= 1'b0;
		end else if (trig || strobe_go) begin
			int_n <= 1'b1;
		end
	end

	// Registered pins; done shows only in one-shot when selected
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_EOC_INT_N <= 1'b1;
			O_SAMPLING <= 1'b0;
			O_CONVERTING <= 1'b0;
		end else begin
			O_EOC_INT_N <= (I_CONFIG_WORD.eoc_select && one_shot) ? !in_conv : int_n;
			O_SAMPLING <= (state == ST_SAMPLE) || (state == ST_EXT_SAMPLE);
			O_CONVERTING <= in_conv;
		end
	end

	// A new operation discards unread results before its first sample
	result_fifo #(.WIDTH($bits(result_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_flush(new_op),
		.i_wr_valid(state == ST_PUSH),
		.o_wr_ready(fifo_ready),
		.i_wr_data(capture),
		.o_rd_valid(O_RESULT_VALID),
		.i_rd_ready(I_RESULT_READY),
		.o_rd_data(O_RESULT_DATA)
	);
endmodule

// >>> testbench/adc_seq_properties.sv
// Port checker of the sample and convert sequencer, bound to its top module
`timescale 1ns/100ps
module adc_seq_properties (
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic I_EXTERNAL_SAMPLE_STROBE_N,
	input wire adc_seq_pkg::config_word_s I_CONFIG_WORD,
	input wire logic I_RESULT_READY,
	input wire logic O_EOC_INT_N,
	input wire logic O_SAMPLING,
	input wire logic O_CONVERTING,
	input wire adc_seq_pkg::result_s O_RESULT_DATA,
	input wire logic O_RESULT_VALID,
	input wire logic O_EXTENDED_MODE,
	input wire logic O_HALTED
);
	import adc_seq_pkg::*;
	logic [9:0] scnt;
	logic [9:0] ccnt;
	logic [9:0] ctarget;
	logic oneshot;
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	// Cycles spent in the current sampling and conversion periods
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			scnt <= 10'h000;
			ccnt <= 10'h000;
		end else begin
			scnt <= O_SAMPLING ? scnt + 10'h001 : 10'h000;
			ccnt <= O_CONVERTING ? ccnt + 10'h001 : 10'h000;
		end
	end
	// Ten clocks per oscillator tick, fifty per four serial clocks
	assign ctarget = I_CONFIG_WORD.ext_clock ? (I_CONFIG_WORD.res14 ? 10'h384 : 10'h28A)
		: (I_CONFIG_WORD.res14 ? 10'h0B4 : 10'h082);
	assign oneshot = I_CONFIG_WORD.mode == MODE_ONE_SHOT;
	// Window ends are serial edges seen through synchronisers, so allow two clocks of jitter
	a_short_window: assert property (
		$fell(O_SAMPLING) && !O_EXTENDED_MODE && !I_CONFIG_WORD.long_sample
		|-> scnt >= 10'h094 && scnt <= 10'h098) else $error("short window length wrong");
	a_long_window: assert property (
		$fell(O_SAMPLING) && !O_EXTENDED_MODE && I_CONFIG_WORD.long_sample
		|-> scnt >= 10'h224 && scnt <= 10'h228) else $error("long window length wrong");
	a_conv_length: assert property (
		$fell(O_CONVERTING) |-> ccnt + 10'h00A >= ctarget && ccnt <= ctarget + 10'h006)
		else $error("conversion length wrong");
	a_eoc_low: assert property (
		$rose(O_CONVERTING) && I_CONFIG_WORD.eoc_select && oneshot
		|-> ##[0:1] (!O_EOC_INT_N [*8])) else $error("done pin not low in conversion");
	a_int_after: assert property (
		$fell(O_CONVERTING) && !I_CONFIG_WORD.eoc_select && oneshot
		|-> ##[0:3] !O_EOC_INT_N) else $error("no interrupt after conversion");
	a_strobe_conv: assert property (
		$rose(I_EXTERNAL_SAMPLE_STROBE_N) && O_SAMPLING && O_EXTENDED_MODE
		|-> ##[3:8] (O_CONVERTING && !O_SAMPLING)) else $error("strobe rise did not convert");
	a_halt_idle: assert property (
		O_HALTED |-> !$rose(O_SAMPLING)) else $error("sampling while halted");
	a_oneshot_nofifo: assert property (
		oneshot && !O_RESULT_VALID |=> !O_RESULT_VALID) else $error("one-shot wrote the fifo");
	a_fifo_hold: assert property (
		O_RESULT_VALID && !I_RESULT_READY
		|=> (O_RESULT_VALID && $stable(O_RESULT_DATA)) or (##[0:1] O_SAMPLING))
		else $error("fifo head lost while stalled");
	// Main scenarios reached
	c_conv: cover property ($fell(O_CONVERTING));
	c_halt: cover property ($rose(O_HALTED));
	c_ext: cover property ($rose(O_EXTENDED_MODE));
	c_stall: cover property (O_RESULT_VALID && !I_RESULT_READY);
endmodule
bind adc_sample_convert_sequencer adc_seq_properties props (.I_CLK, .I_RST_N,
	.I_EXTERNAL_SAMPLE_STROBE_N, .I_CONFIG_WORD, .I_RESULT_READY, .O_EOC_INT_N, .O_SAMPLING,
	.O_CONVERTING, .O_RESULT_DATA, .O_RESULT_VALID, .O_EXTENDED_MODE, .O_HALTED);

// >>> testbench/adc_host_model.sv
// Host side of the serial link: frames, frame sync and sample strobe
`timescale 1ns/100ps
module adc_host_model (
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_fs,
	output logic o_strobe_n
);
	// Idle link: clock stands still high, no select, no sync, strobe released
	initial begin
		o_sclk = 1'b1;
		o_cs_n = 1'b1;
		o_fs = 1'b0;
		o_strobe_n = 1'b1;
	end
	// One frame of n serial periods, opened by select or by sync, never both
	task automatic frame(input int n, input bit use_fs);
		#3.3;
		if (use_fs) begin
			o_fs = 1'b1;
		end else begin
			o_cs_n = 1'b0;
		end
		for (int i = 0; i < n; i++) begin
			#62.5 o_sclk = 1'b0;
			o_fs = 1'b0;
			#62.5 o_sclk = 1'b1;
		end
		#62.5 o_cs_n = 1'b1;
	endtask
	// One sample strobe: pulled low for low_ns, then released
	task automatic strobe(input int low_ns);
		#7.1 o_strobe_n = 1'b0;
		#(low_ns) o_strobe_n = 1'b1;
	endtask
endmodule

// >>> testbench/tb_adc_sample_convert_sequencer.sv
// Self-checking bench of the sample and convert sequencer
`timescale 1ns/100ps
module tb_adc_sample_convert_sequencer;
	import adc_seq_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	cmd_e cmd = CMD_OTHER;
	logic [CH_BITS-1:0] cmd_ch = 3'h0;
	config_word_s cfg = '0;
	logic [VALUE_BITS-1:0] conv = 14'h0000;
	logic ready = 1'b0;
	logic sclk, cs_n, fs, strobe_n, eoc, sampling, converting, valid, ext, op_active, halted;
	logic [CH_BITS-1:0] chan;
	logic [VALUE_BITS-1:0] oneshot;
	result_s rdata;
	result_s expq[$];
	int miscompares = 0;
	int num_checks = 0;
	int nsamp = 0;
	int n0;
	logic [2:0] ch;
	always #5 clk = ~clk;
	// Count every sampling start seen at the outputs
	always @(posedge sampling) nsamp++;
	adc_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_fs(fs), .o_strobe_n(strobe_n));
	adc_sample_convert_sequencer uut (.I_CLK(clk), .I_RST_N(rst_n), .I_SCLK(sclk),
		.I_CS_N(cs_n), .I_FRAME_SYNC_PULSE(fs), .I_EXTERNAL_SAMPLE_STROBE_N(strobe_n),
		.I_CMD(cmd), .I_CMD_CHANNEL(cmd_ch), .I_CONFIG_WORD(cfg), .I_CONV_VALUE(conv),
		.I_RESULT_READY(ready), .O_EOC_INT_N(eoc), .O_SAMPLING(sampling),
		.O_CONVERTING(converting), .O_CHANNEL(chan), .O_ONESHOT_RESULT(oneshot),
		.O_RESULT_DATA(rdata), .O_RESULT_VALID(valid), .O_EXTENDED_MODE(ext),
		.O_OP_ACTIVE(op_active), .O_HALTED(halted));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Wait out the conversion and the push, bounded
	task automatic settle();
		repeat (12) @(negedge clk);
		repeat (2000) begin
			@(negedge clk);
			if (!sampling && !converting) break;
		end
		repeat (6) @(negedge clk);
	endtask
	// One frame with a fresh analog value held until it is captured
	task automatic run(input cmd_e c, input logic [2:0] chn, input int n, input bit use_fs);
		@(negedge clk);
		cmd = c;
		cmd_ch = chn;
		conv = 14'($urandom);
		host.frame(n, use_fs);
		settle();
	endtask
	// Pop the whole fifo with a randomly stalling reader
	task automatic drain();
		repeat (400) begin
			@(negedge clk);
			if (expq.size() == 0) break;
			// Head stands until the edge that pops it, so compare it as ready goes up
			ready = 1'($urandom);
			if (valid === 1'b1 && ready) begin
				check(rdata, expq.pop_front());
			end
		end
		@(negedge clk);
		ready = 1'b0;
		check(expq.size(), 0);
		check(valid, 0);
	endtask
	function automatic logic [2:0] sweep_ch(input int s, input int j);
		case (s)
			0: return 3'(j);
			1: return 3'((j % 4) * 2);
			2: return 3'((j / 2) * 2);
			default: return 3'((j % 2) * 2);
		endcase
	endfunction
	// Watchdog about three times the expected run of about a third of a millisecond
	initial begin
		#900000;
		miscompares++;
		print_verdict();
	end
	initial begin
		void'($urandom(32'h6957));
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		check({eoc, valid, halted, ext}, 4'h8);
		repeat (3) @(negedge clk);
		// One-shot over both windows and both conversion clocks
		for (int i = 0; i < 4; i++) begin
			cfg.long_sample = i[0];
			cfg.eoc_select = i[0];
			cfg.ext_clock = i[1];
			cfg.res14 = 1'($urandom);
			ch = 3'($urandom);
			run(CMD_SELECT, ch, (i[0] ? 48 : 16) + (i[1] ? 76 : 0), 0);
			check(chan, ch);
			check(oneshot, conv);
			check(valid, 0);
			check(eoc, cfg.eoc_select);
		end
		cfg = '0;
		n0 = nsamp;
		run(CMD_CONFIG_WRITE, 3'h0, 16, 0);
		check({nsamp[30:0], eoc}, {n0[30:0], 1'b1});
		// Strobe enters extended mode; two selects leave it
		conv = 14'($urandom);
		host.strobe(600);
		settle();
		check({ext, oneshot}, {1'b1, conv});
		n0 = nsamp;
		run(CMD_SELECT, 3'h0, 16, 0);
		check(nsamp, n0);
		run(CMD_SELECT, 3'h0, 16, 0);
		check(ext, 0);
		// Repeat at every threshold, second operation overwrites the first
		for (int th = 0; th < 4; th++) begin
			cfg.mode = MODE_REPEAT;
			cfg.threshold = 2'(th);
			ch = 3'($urandom);
			for (int k = 0; k < 2; k++) begin
				expq.delete();
				for (int j = 0; j < 8 - 2 * th; j++) begin
					run(CMD_SELECT, (j != 0) ? 3'($urandom) : ch, 16, 0);
					expq.push_back(result_s'({ch, conv}));
				end
				check({eoc, op_active}, 2'h0);
			end
			drain();
		end
		// Sweep halts at threshold; repeat sweep restarts and overwrites
		for (int s = 0; s < 4; s++) begin
			cfg.mode = s[0] ? MODE_REPEAT_SWEEP : MODE_SWEEP;
			cfg.sweep_seq = 2'(s);
			cfg.threshold = 2'($urandom);
			for (int k = 0; k <= s[0]; k++) begin
				expq.delete();
				for (int j = 0; j < 8 - 2 * int'(cfg.threshold); j++) begin
					run(CMD_SELECT, 3'($urandom), 16, 1);
					expq.push_back(result_s'({sweep_ch(s, j), conv}));
				end
			end
			check({halted, eoc}, {1'(!s[0]), 1'b0});
			n0 = nsamp;
			if (!s[0]) begin
				run(CMD_SELECT, 3'h0, 16, 1);
				check(nsamp, n0);
			end
			drain();
			run(CMD_FIFO_READ, 3'h0, 16, 1);
			check({halted, nsamp[30:0]}, {1'b0, n0[30:0]});
		end
		// Strobe-driven sweep halts; read, then the arm frame the host owes
		cfg.mode = MODE_SWEEP;
		cfg.sweep_seq = 2'h1;
		cfg.threshold = 2'h3;
		expq.delete();
		for (int j = 0; j < 2; j++) begin
			conv = 14'($urandom);
			host.strobe(300);
			settle();
			expq.push_back(result_s'({sweep_ch(1, j), conv}));
		end
		check({halted, ext}, 2'h3);
		drain();
		run(CMD_FIFO_READ, 3'h0, 16, 0);
		check(halted, 0);
		run(CMD_SELECT, 3'h0, 16, 0);
		check(ext, 0);
		print_verdict();
	end
endmodule
